// file: rtl/mcar_pkg.sv
// Constants shared by the master configuration and activity register bank.
// Assumes an 8-bit microprocessor bus with 12 address bits.
package mcar_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int J1_OFS_W = 10;
  localparam int SYNC_W = 3 + ADDR_W + DATA_W;

  // Register addresses.
  localparam logic [ADDR_W-1:0] REG_IN_CFG = 12'h000;
  localparam logic [ADDR_W-1:0] REG_OUT_CFG = 12'h001;
  localparam logic [ADDR_W-1:0] REG_ACTIVITY = 12'h002;

  // Reset values and the writable part of the outgoing register.
  localparam logic [DATA_W-1:0] CFG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] OUT_CFG_WMASK = 8'hbf;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

  // Incoming configuration fields.
  localparam int IN_CONCAT = 0;
  localparam int IN_MF_PIN_EN = 1;
  localparam int IN_MF_ON_H4 = 2;
  localparam int IN_ODD_PAR = 3;
  localparam int IN_PAR_FM = 4;
  localparam int IN_PAR_PM = 5;
  localparam int IN_LOP_AIS = 6;
  localparam int IN_PAR_IRQ = 7;

  // Outgoing configuration fields.
  localparam int OUT_CONCAT = 0;
  localparam int OUT_FLOAT = 1;
  localparam int OUT_MF_ON_H4 = 2;
  localparam int OUT_ODD_PAR = 3;
  localparam int OUT_V1_IND = 4;
  localparam int OUT_POH_PT = 5;
  localparam int OUT_LOCKED_OFFSET_ZERO = 7;

  // Activity register fields.
  localparam int ACT_SCLK = 0;
  localparam int ACT_RX_FM = 1;
  localparam int ACT_RX_PM = 2;
  localparam int ACT_RX_MF = 3;
  localparam int ACT_RX_DATA = 4;
  localparam int ACT_TX_FM = 5;
  localparam int ACT_TX_PM = 6;
  localparam int ACT_TX_MF = 7;

  // Locked-mode J1 pointer offsets.
  localparam logic [J1_OFS_W-1:0] J1_OFS_AFTER_H3 = 10'h000;
  localparam logic [J1_OFS_W-1:0] J1_OFS_AFTER_C1 = 10'h20a;
endpackage

// file: rtl/mcar_activity.sv
// Sticky activity monitor for the eight watched inputs.
// Assumes the watched inputs are already in the sys_clk domain.
`timescale 1ns/10ps
module mcar_activity (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [mcar_pkg::DATA_W-1:0] mon,
  input wire logic [mcar_pkg::DATA_W-1:0] rx_data_bus,
  input wire logic clear,
  output logic [mcar_pkg::DATA_W-1:0] act
);
  import mcar_pkg::*;

  logic [DATA_W-1:0] mon_prev_ff;
  logic [DATA_W-1:0] data_prev_ff;
  logic [DATA_W-1:0] data_seen_ff;
  logic [DATA_W-1:0] nxt_data_seen;
  logic [DATA_W-1:0] data_hits;
  logic [DATA_W-1:0] act_ff;
  logic [DATA_W-1:0] nxt_act;
  logic [DATA_W-1:0] set_vec;

  // Rising edges per watched line; the clock bit sets every cycle it runs.
  genvar g;
  generate
    for (g = 0; g < DATA_W; g++) begin : g_edge
      if (g == ACT_SCLK) begin : g_clk
        assign set_vec[g] = 1'b1;
      end else if (g == ACT_RX_DATA) begin : g_bus
        assign set_vec[g] = &data_hits;
      end else begin : g_pin
        assign set_vec[g] = mon[g] & ~mon_prev_ff[g];
      end
    end
  endgenerate

  // Data bus activity needs a rising edge on all eight lines since the read.
  // A set in the clearing cycle survives, so no edge is lost.
  // all lines seen
  assign data_hits = (clear ? BYTE_ZERO : data_seen_ff) |
                     (rx_data_bus & ~data_prev_ff);

  // Tracking restarts once all eight lines have been seen to rise.
  always_comb begin
    nxt_data_seen = (&data_hits) ? BYTE_ZERO : data_hits;
    nxt_act = (clear ? BYTE_ZERO : act_ff) | set_vec;
  end

  // Register the monitor state.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mon_prev_ff <= BYTE_ZERO;
      data_prev_ff <= BYTE_ZERO;
      data_seen_ff <= BYTE_ZERO;
      act_ff <= BYTE_ZERO;
    end else begin
      mon_prev_ff <= mon;
      data_prev_ff <= rx_data_bus;
      data_seen_ff <= nxt_data_seen;
      act_ff <= nxt_act;
    end
  end

  assign act = act_ff;
endmodule // mcar_activity

// file: rtl/mcar_regs.sv
// Master incoming/outgoing configuration and input activity register bank.
// Assumes an asynchronous microprocessor bus (active-low select, read and
// write strobes) whose address and data stay stable around each strobe.
// Behaviour
// - Writes to unused bits do nothing; software writes zero and masks reads.
// - Every writable bit clears to zero on reset.
// - Writes to read-only positions leave operation unchanged.
// - Every writable configuration bit reads back its last written value.
// - Incoming bit 0 high selects AU4, low selects AU3 for receive.
// - Incoming bit 1 picks the marker pin over H4 bytes for multiframes.
// - Incoming bit 2, with bit 1 set, places the marker at H4 or third byte after J1.
// - Incoming parity is checked odd or even per incoming bit 3.
// - Bits 4 and 5 add frame and payload markers to the parity set.
// - Bit 6 inserts AIS on pointer loss, ORed with the tributary enable.
// - Bit 7 lets incoming parity errors drive the active-low interrupt.
// - Outgoing bit 0 high selects AU4, low selects AU3 for transmit.
// - Floating mode holds the locked indicator outputs low.
// - Outgoing marker sets multiframes; bit 2 selects H4 or third byte.
// - Outgoing parity pin makes bus parity even, or odd when bit 3 set.
// - Locked frame indicator marks C1, J1, and V1 when bit 4 is set.
// - Bit 5 copies incoming path overhead, otherwise outgoing overhead is zero.
// - Locked mode places J1 at offset zero or 522 per bit 7.
// - Activity bits set on rising edges and clear on a read; the clock bit sets again every cycle.
// - Writing the activity register ends the interval without touching bits.
// - Data bus activity needs edges on all eight incoming data lines.
`timescale 1ns/10ps
module mcar_regs (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [mcar_pkg::ADDR_W-1:0] addr,
  input wire logic [mcar_pkg::DATA_W-1:0] data_in,
  output logic [mcar_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [mcar_pkg::DATA_W-1:0] rx_data_bus,
  input wire logic rx_parity_pin,
  input wire logic rx_frame_marker,
  input wire logic rx_payload_marker,
  input wire logic rx_multiframe_marker,
  input wire logic tx_frame_marker,
  input wire logic tx_payload_marker,
  input wire logic tx_multiframe_marker,
  input wire logic [mcar_pkg::DATA_W-1:0] tx_byte_in,
  input wire logic tx_c1_slot,
  input wire logic tx_j1_slot,
  input wire logic tx_v1_slot,
  input wire logic tx_payload_slot,
  input wire logic tx_poh_slot,
  input wire logic [mcar_pkg::DATA_W-1:0] rx_poh_byte,
  input wire logic trib_lop_ais_enable,
  output logic [mcar_pkg::DATA_W-1:0] tx_data_bus,
  output logic tx_parity_pin,
  output logic locked_frame_indicator,
  output logic locked_payload_indicator,
  output logic interrupt_out_n,
  output logic rx_parity_err,
  output logic accum_transfer,
  output logic rx_concat_au4,
  output logic rx_multiframe_pin_enable,
  output logic rx_marker_on_h4,
  output logic ais_on_pointer_loss,
  output logic tx_concat_au4,
  output logic tx_floating_mode,
  output logic tx_marker_on_h4,
  output logic path_overhead_passthrough,
  output logic [mcar_pkg::J1_OFS_W-1:0] locked_j1_offset
);
  import mcar_pkg::*;

  // True when a bus address selects the bank register at the given offset.
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  logic [SYNC_W-1:0] bus_s1_ff;
  logic [SYNC_W-1:0] bus_s2_ff;
  logic s_cs_n;
  logic s_rd_n;
  logic s_wr_n;
  logic [ADDR_W-1:0] s_addr;
  logic [DATA_W-1:0] s_data;
  logic rd_act;
  logic wr_act;
  logic rd_act_ff;
  logic wr_act_ff;
  logic [ADDR_W-1:0] rd_addr_ff;
  logic rd_start;
  logic rd_end;
  logic wr_commit;
  logic mapped;
  logic [DATA_W-1:0] in_cfg_ff;
  logic [DATA_W-1:0] nxt_in_cfg;
  logic [DATA_W-1:0] out_cfg_ff;
  logic [DATA_W-1:0] nxt_out_cfg;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic data_oe_ff;
  logic accum_ff;
  logic act_clear;
  logic [DATA_W-1:0] act_bits;
  logic [DATA_W-1:0] mon_vec;
  logic par_bad;
  logic par_err_ff;
  logic irq_n_ff;
  logic [DATA_W-1:0] tx_sel;
  logic [DATA_W-1:0] tx_data_ff;
  logic tx_par_ff;
  logic lfi_ff;
  logic lpi_ff;
  logic nxt_lfi;
  logic nxt_lpi;

  // Two-stage synchroniser for every bus pin; only stage two is read.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bus_s1_ff <= {3'h7, {ADDR_W{1'b0}}, BYTE_ZERO};
      bus_s2_ff <= {3'h7, {ADDR_W{1'b0}}, BYTE_ZERO};
    end else begin
      bus_s1_ff <= {cs_n, rd_n, wr_n, addr, data_in};
      bus_s2_ff <= bus_s1_ff;
    end
  end

  // Strobe decoding and edge detection on the synchronised pins.
  assign {s_cs_n, s_rd_n, s_wr_n, s_addr, s_data} = bus_s2_ff;
  assign rd_act = ~s_cs_n & ~s_rd_n;
  assign wr_act = ~s_cs_n & ~s_wr_n;
  assign rd_start = rd_act & ~rd_act_ff;
  assign rd_end = ~rd_act & rd_act_ff;
  assign wr_commit = ~wr_act & wr_act_ff;
  assign mapped = hit(s_addr, REG_IN_CFG) | hit(s_addr, REG_OUT_CFG) |
                  hit(s_addr, REG_ACTIVITY);
  assign act_clear = rd_end & hit(rd_addr_ff, REG_ACTIVITY);

  // Configuration writes commit on the trailing edge of the write strobe.
  always_comb begin
    nxt_in_cfg = in_cfg_ff;
    nxt_out_cfg = out_cfg_ff;
    if (wr_commit && hit(s_addr, REG_IN_CFG)) begin
      nxt_in_cfg = s_data;
    end
    if (wr_commit && hit(s_addr, REG_OUT_CFG)) begin
      nxt_out_cfg = s_data & OUT_CFG_WMASK;
    end
  end

  // Read data is captured once at the start of the read strobe.
  always_comb begin
    nxt_rdata = rdata_ff;
    if (rd_start) begin
      if (hit(s_addr, REG_IN_CFG)) begin
        nxt_rdata = in_cfg_ff;
      end else if (hit(s_addr, REG_OUT_CFG)) begin
        nxt_rdata = out_cfg_ff;
      end else if (hit(s_addr, REG_ACTIVITY)) begin
        nxt_rdata = act_bits;
      end else begin
        nxt_rdata = BYTE_ZERO;
      end
    end
  end

  // Register bank state; reset clears every writable bit.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      in_cfg_ff <= CFG_RESET;
      out_cfg_ff <= CFG_RESET;
      rdata_ff <= BYTE_ZERO;
      rd_act_ff <= 1'b0;
      wr_act_ff <= 1'b0;
      rd_addr_ff <= {ADDR_W{1'b0}};
      data_oe_ff <= 1'b0;
      accum_ff <= 1'b0;
    end else begin
      in_cfg_ff <= nxt_in_cfg;
      out_cfg_ff <= nxt_out_cfg;
      rdata_ff <= nxt_rdata;
      rd_act_ff <= rd_act;
      wr_act_ff <= wr_act;
      rd_addr_ff <= rd_start ? s_addr : rd_addr_ff;
      data_oe_ff <= rd_act & mapped;
      accum_ff <= wr_commit & hit(s_addr, REG_ACTIVITY);
    end
  end

  // Activity monitors on the watched inputs.
  assign mon_vec = {tx_multiframe_marker, tx_payload_marker,
                    tx_frame_marker, 1'b0, rx_multiframe_marker,
                    rx_payload_marker, rx_frame_marker, 1'b0};

  mcar_activity u_activity (
    .sys_clk(sys_clk),
    .reset(reset),
    .mon(mon_vec),
    .rx_data_bus(rx_data_bus),
    .clear(act_clear),
    .act(act_bits)
  );

  // Incoming parity over data, parity pin and the selected markers.
  // odd or even check
  assign par_bad = (^{rx_data_bus, rx_parity_pin,
                      rx_frame_marker & in_cfg_ff[IN_PAR_FM],
                      rx_payload_marker & in_cfg_ff[IN_PAR_PM]})
                   != in_cfg_ff[IN_ODD_PAR];

  // Parity error pulse and gated active-low interrupt, every clock.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      par_err_ff <= 1'b0;
      irq_n_ff <= 1'b1;
    end else begin
      par_err_ff <= par_bad;
      irq_n_ff <= ~(par_bad & in_cfg_ff[IN_PAR_IRQ]);
    end
  end

  // Outgoing byte: path overhead slots are zeroed or passed through.
  always_comb begin
    tx_sel = tx_byte_in;
    if (tx_poh_slot) begin
      tx_sel = out_cfg_ff[OUT_POH_PT] ? rx_poh_byte : BYTE_ZERO;
    end
    nxt_lfi = ~out_cfg_ff[OUT_FLOAT] & (tx_c1_slot | tx_j1_slot |
              (tx_v1_slot & out_cfg_ff[OUT_V1_IND]));
    nxt_lpi = ~out_cfg_ff[OUT_FLOAT] & tx_payload_slot;
  end

  // Output byte, its parity and the locked indicators.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_data_ff <= BYTE_ZERO;
      tx_par_ff <= 1'b0;
      lfi_ff <= 1'b0;
      lpi_ff <= 1'b0;
    end else begin
      tx_data_ff <= tx_sel;
      tx_par_ff <= ^tx_sel ^ out_cfg_ff[OUT_ODD_PAR];
      lfi_ff <= nxt_lfi;
      lpi_ff <= nxt_lpi;
    end
  end

  // Processor bus, interrupt, datapath and mode outputs.
  assign data_out = rdata_ff;
  assign data_oe = data_oe_ff;
  assign tx_data_bus = tx_data_ff;
  assign tx_parity_pin = tx_par_ff;
  assign locked_frame_indicator = lfi_ff;
  assign locked_payload_indicator = lpi_ff;
  assign interrupt_out_n = irq_n_ff;
  assign rx_parity_err = par_err_ff;
  assign accum_transfer = accum_ff;
  assign rx_concat_au4 = in_cfg_ff[IN_CONCAT];
  assign rx_multiframe_pin_enable = in_cfg_ff[IN_MF_PIN_EN];
  assign rx_marker_on_h4 = in_cfg_ff[IN_MF_ON_H4] & in_cfg_ff[IN_MF_PIN_EN];
  assign ais_on_pointer_loss = in_cfg_ff[IN_LOP_AIS] | trib_lop_ais_enable;
  assign tx_concat_au4 = out_cfg_ff[OUT_CONCAT];
  assign tx_floating_mode = out_cfg_ff[OUT_FLOAT];
  assign tx_marker_on_h4 = out_cfg_ff[OUT_MF_ON_H4];
  assign path_overhead_passthrough = out_cfg_ff[OUT_POH_PT];
  assign locked_j1_offset = out_cfg_ff[OUT_LOCKED_OFFSET_ZERO] ? J1_OFS_AFTER_H3 :
                            J1_OFS_AFTER_C1;

  // Checks on the register bank and datapath outputs.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  chk_reset_zero: assert property (
    $past(reset) |-> (in_cfg_ff == CFG_RESET && out_cfg_ff == CFG_RESET))
    else $error("configuration not zero after reset");
  chk_unused_zero: assert property (
    (out_cfg_ff & ~OUT_CFG_WMASK) == BYTE_ZERO)
    else $error("unused outgoing bit is not zero");
  chk_cfg_readback: assert property (
    rd_start && hit(s_addr, REG_IN_CFG) |=> data_out == $past(in_cfg_ff))
    else $error("incoming config read back wrong");
  chk_rx_parity_err: assert property (
    !$past(in_cfg_ff[IN_PAR_FM]) && !$past(in_cfg_ff[IN_PAR_PM]) &&
    ((^$past({rx_data_bus, rx_parity_pin})) != $past(in_cfg_ff[IN_ODD_PAR]))
    |-> rx_parity_err)
    else $error("incoming parity error missed");
  chk_irq_gated: assert property (
    !$past(in_cfg_ff[IN_PAR_IRQ]) |-> interrupt_out_n)
    else $error("interrupt raised while disabled");
  chk_irq_on_err: assert property (
    rx_parity_err && $past(in_cfg_ff[IN_PAR_IRQ]) |-> !interrupt_out_n)
    else $error("parity error did not interrupt");
  chk_tx_parity: assert property (
    (^{tx_data_bus, tx_parity_pin}) == $past(out_cfg_ff[OUT_ODD_PAR]))
    else $error("outgoing parity wrong");
  chk_float_low: assert property (
    $past(out_cfg_ff[OUT_FLOAT]) |->
    !locked_frame_indicator && !locked_payload_indicator)
    else $error("locked indicator active in floating mode");
  chk_act_sticky: assert property (
    act_bits[ACT_RX_MF] && !act_clear |=> act_bits[ACT_RX_MF])
    else $error("activity bit lost without a read");
  chk_write_keeps: assert property (
    accum_transfer && !act_clear |=>
    (($past(act_bits) & ~act_bits) == BYTE_ZERO))
    else $error("activity bits changed by a write");
  chk_poh_zero: assert property (
    tx_poh_slot && !out_cfg_ff[OUT_POH_PT] |=> tx_data_bus == BYTE_ZERO)
    else $error("overhead not zeroed");

  cov_accum: cover property (accum_transfer);
  cov_par_irq: cover property (rx_parity_err && !interrupt_out_n);
  cov_act_read: cover property (act_clear && act_bits[ACT_TX_FM]);
endmodule // mcar_regs

// file: sim/mcar_cpu_model.sv
// Microprocessor model for the register bank's parallel bus.
// Assumes the bank samples its strobes on the rising edge of sys_clk.
`timescale 1ns/10ps
module mcar_cpu_model (
  input wire logic sys_clk,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [mcar_pkg::ADDR_W-1:0] addr,
  output logic [mcar_pkg::DATA_W-1:0] data_in,
  input wire logic [mcar_pkg::DATA_W-1:0] data_out,
  input wire logic data_oe
);
  import mcar_pkg::*;

  // The bus starts idle with strobes high.
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 12'h000;
    data_in = 8'h55;
  end

  // Waits n edges, then steps past the edge by the drive delay.
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Holds address and data well past the strobe rise.
  // callers may write unused bits as one.
  task automatic bus_write(input logic [ADDR_W-1:0] a,
                           input logic [DATA_W-1:0] d);
    step(1);
    addr = a;
    data_in = d;
    cs_n = 1'b0;
    wr_n = 1'b0;
    step(4);
    cs_n = 1'b1;
    wr_n = 1'b1;
    step(5);
    data_in = ~d; // Released data no longer shows the written value.
  endtask

  // Holds the read until the output enable is seen, within a bound.
  task automatic bus_read(input logic [ADDR_W-1:0] a,
                          output logic [DATA_W-1:0] d, output bit ok);
    int n;
    ok = 1'b0;
    d = 8'h00;
    step(1);
    addr = a;
    cs_n = 1'b0;
    rd_n = 1'b0;
    for (n = 0; n < 8 && !ok; n++) begin
      @(posedge sys_clk);
      if (data_oe === 1'b1) begin
        ok = 1'b1;
        d = data_out;
      end
    end
    #1;
    cs_n = 1'b1;
    rd_n = 1'b1;
    step(4);
  endtask
endmodule // mcar_cpu_model

// file: sim/test_mcar_regs.sv
// Self-checking bench for the master configuration and activity bank.
// Assumes the bus model in mcar_cpu_model and a 250 MHz sys_clk.
`timescale 1ns/10ps
module test_mcar_regs;
  import mcar_pkg::*;
  logic sys_clk, reset, cs_n, rd_n, wr_n, data_oe;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data_in, data_out, rx_data_bus, tx_byte_in;
  logic [DATA_W-1:0] rx_poh_byte, tx_data_bus;
  logic rx_parity_pin, rx_frame_marker, rx_payload_marker;
  logic rx_multiframe_marker, tx_frame_marker, tx_payload_marker;
  logic tx_multiframe_marker, tx_c1_slot, tx_j1_slot, tx_v1_slot;
  logic tx_payload_slot, tx_poh_slot, trib_lop_ais_enable;
  logic tx_parity_pin, locked_frame_indicator, locked_payload_indicator;
  logic interrupt_out_n, rx_parity_err, accum_transfer, rx_concat_au4;
  logic rx_multiframe_pin_enable, rx_marker_on_h4, ais_on_pointer_loss;
  logic tx_concat_au4, tx_floating_mode, tx_marker_on_h4;
  logic path_overhead_passthrough;
  logic [J1_OFS_W-1:0] locked_j1_offset;
  int err_total, n_checks, n_accum;

  mcar_regs u_mcar_regs (
    .sys_clk(sys_clk), .reset(reset), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .rx_data_bus(rx_data_bus),
    .rx_parity_pin(rx_parity_pin), .rx_frame_marker(rx_frame_marker),
    .rx_payload_marker(rx_payload_marker),
    .rx_multiframe_marker(rx_multiframe_marker),
    .tx_frame_marker(tx_frame_marker),
    .tx_payload_marker(tx_payload_marker),
    .tx_multiframe_marker(tx_multiframe_marker),
    .tx_byte_in(tx_byte_in), .tx_c1_slot(tx_c1_slot),
    .tx_j1_slot(tx_j1_slot), .tx_v1_slot(tx_v1_slot),
    .tx_payload_slot(tx_payload_slot), .tx_poh_slot(tx_poh_slot),
    .rx_poh_byte(rx_poh_byte), .trib_lop_ais_enable(trib_lop_ais_enable),
    .tx_data_bus(tx_data_bus), .tx_parity_pin(tx_parity_pin),
    .locked_frame_indicator(locked_frame_indicator),
    .locked_payload_indicator(locked_payload_indicator),
    .interrupt_out_n(interrupt_out_n), .rx_parity_err(rx_parity_err),
    .accum_transfer(accum_transfer), .rx_concat_au4(rx_concat_au4),
    .rx_multiframe_pin_enable(rx_multiframe_pin_enable),
    .rx_marker_on_h4(rx_marker_on_h4),
    .ais_on_pointer_loss(ais_on_pointer_loss),
    .tx_concat_au4(tx_concat_au4), .tx_floating_mode(tx_floating_mode),
    .tx_marker_on_h4(tx_marker_on_h4),
    .path_overhead_passthrough(path_overhead_passthrough),
    .locked_j1_offset(locked_j1_offset)
  );

  mcar_cpu_model u_mcar_cpu_model (
    .sys_clk(sys_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe)
  );

  // Free-running 4 ns clock.
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Counts accumulation pulses so a write can be judged afterwards.
  always @(posedge sys_clk) begin
    if (accum_transfer === 1'b1) n_accum++;
  end

  // Prints the verdict and stops the run.
  task automatic end_of_test();
    if (err_total == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Moves past n edges by the drive delay.
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    u_mcar_cpu_model.bus_write(a, d);
  endtask

  // Reads a mapped register; a missing answer ends the run.
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    logic [7:0] d;
    bit ok;
    u_mcar_cpu_model.bus_read(a, d, ok);
    if (ok !== 1'b1) begin
      err_total++;
      end_of_test();
    end
    chk(d, e);
  endtask

  // Reset values of both configuration registers and their outputs.
  task automatic t_reset();
    rd_chk(REG_IN_CFG, CFG_RESET);
    rd_chk(REG_OUT_CFG, CFG_RESET);
    chk(interrupt_out_n, 1'b1);
    chk(ais_on_pointer_loss, 1'b0);
    chk(locked_j1_offset, J1_OFS_AFTER_C1);
  endtask

  // Readback, decoded outputs, unused bit and an unmapped address.
  task automatic t_config();
    logic [7:0] d;
    bit ok;
    trib_lop_ais_enable = 1'b1;
    wr(REG_IN_CFG, 8'ha5);
    rd_chk(REG_IN_CFG, 8'ha5);
    chk({rx_concat_au4, rx_multiframe_pin_enable, rx_marker_on_h4,
         ais_on_pointer_loss}, 4'h9);
    trib_lop_ais_enable = 1'b0;
    wr(REG_IN_CFG, 8'h5e);
    rd_chk(REG_IN_CFG, 8'h5e);
    chk({rx_concat_au4, rx_multiframe_pin_enable, rx_marker_on_h4,
         ais_on_pointer_loss}, 4'h7);
    wr(REG_OUT_CFG, 8'hff);
    rd_chk(REG_OUT_CFG, OUT_CFG_WMASK);
    chk({tx_concat_au4, tx_floating_mode, tx_marker_on_h4,
         path_overhead_passthrough}, 4'hf);
    chk(locked_j1_offset, J1_OFS_AFTER_H3);
    wr(REG_OUT_CFG, 8'h40);
    rd_chk(REG_OUT_CFG, BYTE_ZERO);
    chk(locked_j1_offset, J1_OFS_AFTER_C1);
    wr(12'h003, 8'hff);
    rd_chk(REG_IN_CFG, 8'h5e);
    u_mcar_cpu_model.bus_read(12'h003, d, ok);
    chk(ok, 1'b0);
  endtask

  // Every parity mode and set membership, then a per-clock flip.
  task automatic t_parity();
    logic [7:0] c;
    logic e;
    for (int i = 0; i < 16; i++) begin
      c = 8'h00;
      c[IN_ODD_PAR] = i[0];
      c[IN_PAR_FM] = i[1];
      c[IN_PAR_PM] = i[2];
      c[IN_PAR_IRQ] = i[0] ^ i[3];
      wr(REG_IN_CFG, c);
      rx_data_bus = {4'h0, i[3:0]};
      rx_parity_pin = i[1];
      rx_frame_marker = i[3];
      rx_payload_marker = i[2] ^ i[3];
      e = (^rx_data_bus ^ rx_parity_pin ^ (rx_frame_marker & i[1])
           ^ (rx_payload_marker & i[2])) != i[0];
      tick(2);
      chk({rx_parity_err, interrupt_out_n},
          {e, ~(e & c[IN_PAR_IRQ])});
      rx_parity_pin = ~rx_parity_pin;
      tick(1);
      chk({rx_parity_err, interrupt_out_n},
          {~e, ~(~e & c[IN_PAR_IRQ])});
    end
  endtask

  // Outgoing parity, overhead zeroing and indicator behaviour.
  task automatic t_tx();
    logic [7:0] c;
    logic [7:0] e;
    tx_c1_slot = 1'b1;
    tx_v1_slot = 1'b1;
    for (int j = 0; j < 8; j++) begin
      c = 8'h02;
      c[OUT_ODD_PAR] = j[0];
      c[OUT_POH_PT] = j[1];
      wr(REG_OUT_CFG, c);
      tx_byte_in = 8'h35 ^ j[7:0];
      rx_poh_byte = 8'hc3;
      tx_poh_slot = j[2];
      e = j[2] ? (j[1] ? rx_poh_byte : 8'h00) : tx_byte_in;
      tick(1);
      chk({tx_data_bus, tx_parity_pin}, {e, ^e ^ j[0]});
      chk({locked_frame_indicator, locked_payload_indicator}, 2'b00);
    end
    tx_c1_slot = 1'b0;
    wr(REG_OUT_CFG, 8'h00);
    chk(locked_frame_indicator, 1'b0);
    wr(REG_OUT_CFG, 8'h10);
    chk(locked_frame_indicator, 1'b1);
    // frame mark stays high while C1 replaces V1.
    tx_v1_slot = 1'b0;
    tx_c1_slot = 1'b1;
    tick(1);
    chk(locked_frame_indicator, 1'b1);
    // J1 alone and the payload slot drive both locked indicators.
    tx_c1_slot = 1'b0;
    tx_j1_slot = 1'b1;
    tx_payload_slot = 1'b1;
    tick(1);
    chk({locked_frame_indicator, locked_payload_indicator}, 2'b11);
    tx_j1_slot = 1'b0;
    tx_payload_slot = 1'b0;
  endtask

  // Sticky activity, clear on read, and the accumulation write.
  task automatic t_activity();
    logic [7:0] d;
    bit ok;
    int n0;
    {rx_frame_marker, rx_payload_marker, rx_multiframe_marker} = 3'b000;
    {tx_frame_marker, tx_payload_marker, tx_multiframe_marker} = 3'b000;
    rx_data_bus = 8'h00;
    u_mcar_cpu_model.bus_read(REG_ACTIVITY, d, ok);
    rd_chk(REG_ACTIVITY, 8'h01);
    {rx_frame_marker, rx_payload_marker, rx_multiframe_marker} = 3'b111;
    {tx_frame_marker, tx_payload_marker, tx_multiframe_marker} = 3'b111;
    rx_data_bus = 8'h7f;
    tick(1);
    {rx_frame_marker, rx_payload_marker, rx_multiframe_marker} = 3'b000;
    {tx_frame_marker, tx_payload_marker, tx_multiframe_marker} = 3'b000;
    tick(1);
    rd_chk(REG_ACTIVITY, 8'hef);
    rx_data_bus = 8'h00;
    tick(1);
    rx_data_bus = 8'hff;
    tick(1);
    n0 = n_accum;
    // the write must raise exactly one accumulation pulse.
    wr(REG_ACTIVITY, 8'h00);
    chk(16'(n_accum - n0), 16'h0001);
    rd_chk(REG_ACTIVITY, 8'h11);
    rd_chk(REG_ACTIVITY, 8'h01);
  endtask

  // Main sequence: reset, then each scenario in turn.
  initial begin
    err_total = 0;
    n_checks = 0;
    n_accum = 0;
    reset = 1'b1;
    rx_data_bus = 8'h00;
    tx_byte_in = 8'h00;
    rx_poh_byte = 8'h00;
    {rx_parity_pin, rx_frame_marker, rx_payload_marker} = 3'b000;
    {rx_multiframe_marker, tx_frame_marker, tx_payload_marker} = 3'b000;
    {tx_multiframe_marker, tx_c1_slot, tx_j1_slot, tx_v1_slot} = 4'h0;
    {tx_payload_slot, tx_poh_slot, trib_lop_ais_enable} = 3'b000;
    tick(8);
    reset = 1'b0;
    t_reset();
    t_config();
    t_parity();
    t_tx();
    t_activity();
    end_of_test();
  end
endmodule // test_mcar_regs
